// ==== fkas_top.sv ====
// Flash key protection and memory array select, reached over APB
// Notes on behaviour
// - Copy request set only while key is A5
// - Other key values refuse copy request
// - Program/erase takes effect only with key 5A
// - Other keys hold software protection state
// - Key register 8-bit RW, resets to 00
// - Select register AA selects user boot array
// - Any other select value maps user array
// - User boot mode reset gives select AA
// - Other reset modes give select 00
// - Odd select bits carry boot-mode reset value
// - User programming mode blocks boot array select
// - Copy request starts copy of chosen routine
`timescale 1ns/1ps
module fkas_top
	import fkas_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Mode pins
	input  wire logic        user_boot_mode_i,
	input  wire logic        user_prog_mode_i,
	// Flash array side
	input  wire logic        pe_request_i,
	output logic             boot_array_sel_o,
	output logic             pe_enable_o,
	output logic             copy_busy_o,
	output logic [1:0]       copy_routine_o
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] boot_sync;
	logic [1:0] prog_sync;
	logic [1:0] pe_sync;

	// Mode pins run through reset, so the boot level is settled at release
	always_ff @(posedge clk_i) begin
		boot_sync <= {boot_sync[0], user_boot_mode_i};
		prog_sync <= {prog_sync[0], user_prog_mode_i};
	end

	// Request pin crosses in from outside the clock domain
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pe_sync <= 2'b00;
		end else begin
			pe_sync <= {pe_sync[0], pe_request_i};
		end
	end

	wire boot_mode_s = boot_sync[1];
	wire prog_mode_s = prog_sync[1];
	wire pe_req_s    = pe_sync[1];

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic [7:0] flash_protect_key;
	logic [7:0] flash_array_select;
	logic [1:0] code_select;
	logic       reset_seen;
	logic       copy_busy;
	logic       copy_done;
	logic [1:0] copy_routine;

	wire access     = psel_i & penable_i;
	// Writes land only at the completing edge, with pready high
	wire wr         = access & pwrite_i & pready_o;
	wire hit_key    = (paddr_i == FKAS_OFS_KEY);
	wire hit_select = (paddr_i == FKAS_OFS_SELECT);
	wire hit_copy   = (paddr_i == FKAS_OFS_COPY_CTRL);
	wire hit_code   = (paddr_i == FKAS_OFS_CODE_SEL);
	wire hit_status = (paddr_i == FKAS_OFS_STATUS);
	wire mapped     = hit_key | hit_select | hit_copy | hit_code | hit_status;

	// ----------------------------------------
	// Permission decode
	// ----------------------------------------
	// Compared with the live key, so a rewrite withdraws permission at once
	wire copy_allowed = (flash_protect_key == FKAS_KEY_COPY);
	wire pe_allowed   = (flash_protect_key == FKAS_KEY_PROGRAM);
	wire copy_write   = wr & hit_copy & pwdata_i[FKAS_BIT_COPY_REQ];
	wire copy_start   = copy_write & copy_allowed & ~copy_busy;
	// Boot array only for AA, never while in user programming mode
	wire boot_sel     = (flash_array_select == FKAS_SEL_BOOT) & ~prog_mode_s;

	// Status word: array in use, permissions, copy busy
	wire [31:0] status_word = {28'h0000000,
	                           copy_busy, pe_allowed, copy_allowed, boot_sel};

	// Read multiplexer; copy request bit reads as zero
	wire [31:0] rd_data = hit_key    ? {24'h000000, flash_protect_key}  :
	                      hit_select ? {24'h000000, flash_array_select} :
	                      hit_code   ? {30'h00000000, code_select}      :
	                      hit_status ? status_word                      : 32'h00000000;

	// ----------------------------------------
	// Key and code select registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_protect_key <= FKAS_KEY_RESET;
			code_select       <= 2'b00;
		end else begin
			if (wr & hit_key)
				flash_protect_key <= pwdata_i[7:0];
			// Selection cleared once its copy completes; a new write wins
			if (wr & hit_code)
				code_select <= pwdata_i[1:0];
			else if (copy_done)
				code_select <= 2'b00;
		end
	end

	// ----------------------------------------
	// Array select register
	// ----------------------------------------
	// Boot mode is sampled after release, so reset loads a constant first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_array_select <= FKAS_SEL_RESET;
			reset_seen         <= 1'b0;
		end else begin
			reset_seen <= 1'b1;
			if (wr & hit_select)
				flash_array_select <= pwdata_i[7:0];
			else if (!reset_seen)
				flash_array_select <= boot_mode_s ? FKAS_SEL_ODD_MASK
				                                  : FKAS_SEL_RESET;
		end
	end
	// Software is expected to switch arrays only from RAM code

	// ----------------------------------------
	// Copy engine
	// ----------------------------------------
	fkas_copy_engine u_copy (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.start_i    (copy_start),
		.code_sel_i (code_select),
		.busy_o     (copy_busy),
		.done_o     (copy_done),
		.routine_o  (copy_routine)
	);

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prdata_o         <= 32'h00000000;
			pready_o         <= 1'b0;
			pslverr_o        <= 1'b0;
			boot_array_sel_o <= 1'b0;
			pe_enable_o      <= 1'b0;
			copy_busy_o      <= 1'b0;
			copy_routine_o   <= 2'b00;
		end else begin
			// One wait state: answer the cycle after penable rises
			pready_o         <= access & ~pready_o;
			pslverr_o        <= access & ~pready_o & ~mapped;
			prdata_o         <= (access & ~pwrite_i) ? rd_data : 32'h00000000;
			boot_array_sel_o <= boot_sel;
			pe_enable_o      <= pe_req_s & pe_allowed;
			copy_busy_o      <= copy_busy;
			copy_routine_o   <= copy_routine;
		end
	end

endmodule

// ==== fkas_pkg.sv ====
// Package: register map, key values and reset values for the flash key/array select block
package fkas_pkg;
	// Register byte offsets on APB
	localparam logic [7:0] FKAS_OFS_KEY       = 8'h00;
	localparam logic [7:0] FKAS_OFS_SELECT    = 8'h04;
	localparam logic [7:0] FKAS_OFS_COPY_CTRL = 8'h08;
	localparam logic [7:0] FKAS_OFS_CODE_SEL  = 8'h0C;
	localparam logic [7:0] FKAS_OFS_STATUS    = 8'h10;
	// Key codes
	localparam logic [7:0] FKAS_KEY_COPY      = 8'hA5;
	localparam logic [7:0] FKAS_KEY_PROGRAM   = 8'h5A;
	localparam logic [7:0] FKAS_KEY_RESET     = 8'h00;
	// Array select codes and reset values
	localparam logic [7:0] FKAS_SEL_BOOT      = 8'hAA;
	localparam logic [7:0] FKAS_SEL_ODD_MASK  = 8'hAA;
	localparam logic [7:0] FKAS_SEL_RESET     = 8'h00;
	// Field positions
	localparam int         FKAS_BIT_COPY_REQ  = 0;
	localparam int         FKAS_BIT_PROG_SEL  = 0;
	localparam int         FKAS_BIT_ERASE_SEL = 1;
	localparam int         FKAS_BIT_ST_BOOT   = 0;
	localparam int         FKAS_BIT_ST_COPYEN = 1;
	localparam int         FKAS_BIT_ST_PROGEN = 2;
	localparam int         FKAS_BIT_ST_BUSY   = 3;
	// Copy engine timing
	localparam logic [7:0] FKAS_COPY_CYCLES   = 8'h10;
	localparam logic [7:0] FKAS_COUNT_ZERO    = 8'h00;
	localparam logic [7:0] FKAS_COUNT_ONE     = 8'h01;
	// Copy engine states
	typedef enum logic [1:0] {
		FKAS_IDLE = 2'b01,
		FKAS_COPY = 2'b10
	} fkas_copy_state_t;
endpackage

// ==== fkas_copy_engine.sv ====
// Copy engine: sequences the automatic routine copy into on-chip RAM
`timescale 1ns/1ps
module fkas_copy_engine
	import fkas_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       start_i,
	input  wire logic [1:0] code_sel_i,
	// Status
	output logic            busy_o,
	output logic            done_o,
	output logic [1:0]      routine_o
);

	fkas_copy_state_t state;
	logic [7:0]       count;

	// Fixed-length copy; RAM side is outside this block
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state     <= FKAS_IDLE;
			count     <= FKAS_COUNT_ZERO;
			busy_o    <= 1'b0;
			done_o    <= 1'b0;
			routine_o <= 2'b00;
		end else begin
			done_o <= 1'b0;
			unique case (state)
				FKAS_IDLE: begin
					if (start_i) begin
						state     <= FKAS_COPY;
						count     <= FKAS_COPY_CYCLES;
						busy_o    <= 1'b1;
						routine_o <= code_sel_i;
					end
				end
				FKAS_COPY: begin
					count <= count - FKAS_COUNT_ONE;
					if (count == FKAS_COUNT_ONE) begin
						state  <= FKAS_IDLE;
						busy_o <= 1'b0;
						done_o <= 1'b1;
					end
				end
				default: begin
					state  <= FKAS_IDLE;
					busy_o <= 1'b0;
				end
			endcase
		end
	end

endmodule

// ==== fkas_sva.sv ====
// Checker: key and array-select relations at the top ports
`timescale 1ns/1ps
module fkas_sva
	import fkas_pkg::*;
(
	// Clock, reset and APB
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	// Mode and flash side
	input wire logic        user_prog_mode_i,
	input wire logic        boot_array_sel_o,
	input wire logic        pe_enable_o,
	input wire logic        copy_busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow key, written on the completing access edge
	logic [7:0] key;
	wire logic wr = psel_i && penable_i && pready_o && pwrite_i;
	wire logic sel_wr = wr && paddr_i == 8'h04;
	wire logic cp_ok = wr && paddr_i == 8'h08 && pwdata_i[0] && key == FKAS_KEY_COPY;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			key <= FKAS_KEY_RESET;
		else if (wr && paddr_i == 8'h00)
			key <= pwdata_i[7:0];
	end
	// ----------
	// Properties
	// ----------
	property p_rdy; psel_i && penable_i && !pready_o |=> pready_o; endproperty
	a_rdy: assert property (p_rdy) else $error("access not ended");
	property p_err; pready_o |-> pslverr_o == !(paddr_i inside {8'h00, 8'h04,
		8'h08, 8'h0C, 8'h10}); endproperty
	a_err: assert property (p_err) else $error("bad slave error");
	property p_key; pready_o && !pwrite_i && paddr_i == 8'h00 |-> prdata_o == {24'h0, key};
	endproperty
	a_key: assert property (p_key) else $error("key read wrong");
	property p_pe; pe_enable_o |-> key == 8'h5A || $past(key) == 8'h5A; endproperty
	a_pe: assert property (p_pe) else $error("enable without key");
	property p_copy; $rose(copy_busy_o) |-> $past(cp_ok, 2); endproperty
	a_copy: assert property (p_copy) else $error("copy without key");
	property p_user; sel_wr && pwdata_i[7:0] != 8'hAA |-> ##[1:2] !boot_array_sel_o;
	endproperty
	a_user: assert property (p_user) else $error("user array not mapped");
	property p_boot; !user_prog_mode_i [*4] ##0 sel_wr && pwdata_i[7:0] == 8'hAA
		|-> ##[1:2] boot_array_sel_o; endproperty
	a_boot: assert property (p_boot) else $error("boot array not mapped");
	property p_prog; user_prog_mode_i [*4] |-> !boot_array_sel_o; endproperty
	a_prog: assert property (p_prog) else $error("boot array in prog mode");
	// Main scenarios reached
	cover property ($rose(copy_busy_o));
	cover property (pready_o && pslverr_o);
	cover property ($rose(boot_array_sel_o));
endmodule

bind fkas_top fkas_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.user_prog_mode_i(user_prog_mode_i), .boot_array_sel_o(boot_array_sel_o),
	.pe_enable_o(pe_enable_o), .copy_busy_o(copy_busy_o));

// ==== fkas_cpu.sv ====
// Partner model: CPU software issuing APB transfers from on-chip RAM
`timescale 1ns/1ps
module fkas_cpu (
	// Clock and answer
	input  wire logic        clk_i,
	input  wire logic        pready_i,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pslverr_i,
	// Request
	output logic             psel_o = 0,
	output logic             penable_o = 0,
	output logic             pwrite_o = 0,
	output logic [7:0]       paddr_o = 0,
	output logic [31:0]      pwdata_o = 0
);
	// Runs from RAM, so select writes never pull code from under it
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_i);
		psel_o <= 1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1;
		// Wait is unbounded here; the bench timeout ends a hang
		do @(posedge clk_i); while (pready_i !== 1'b1);
		r = prdata_i;
		e = pslverr_i;
		psel_o <= 0;
		penable_o <= 0;
	endtask
endmodule

// ==== fkas_top_test.sv ====
// Testbench: key and array-select block driven by the CPU model
`timescale 1ns/1ps
module fkas_top_test;
	import fkas_pkg::*;
	logic        clk_i = 0, rst_i = 1, boot = 0, prog = 0, pe_req = 0, e, sel, pe, busy;
	logic        psel, pen, pwr, rdy, err;
	logic [7:0]  addr;
	logic [31:0] wd, rdat, r;
	logic [1:0]  rout;
	int          n_mismatch = 0, checks = 0, seed = 83, cyc = 0, key, v;
	logic [7:0]  sels [5] = '{8'hAA, 8'h55, 8'hAB, 8'h00, 8'hAA};

	always #5 clk_i = ~clk_i;
	fkas_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wd), .prdata_o(rdat), .pready_o(rdy),
		.pslverr_o(err), .user_boot_mode_i(boot), .user_prog_mode_i(prog),
		.pe_request_i(pe_req), .boot_array_sel_o(sel), .pe_enable_o(pe),
		.copy_busy_o(busy), .copy_routine_o(rout));
	fkas_cpu cpu_u (.clk_i(clk_i), .pready_i(rdy), .prdata_i(rdat), .pslverr_i(err),
		.psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(addr), .pwdata_o(wd));

	task summarize();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", s, x, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		cpu_u.xfer(1, a, d, r, e);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x, input string s);
		cpu_u.xfer(0, a, 0, r, e);
		chk(s, x, r);
	endtask
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk_i) begin
		if (++cyc == 5000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		repeat (3) @(posedge clk_i);
		rd(8'h04, 0, "select");
		rd(8'h00, 0, "key");
		// Second reset in boot mode; pin steady long before release
		rst_i <= 1;
		boot <= 1;
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		repeat (3) @(posedge clk_i);
		rd(8'h04, 32'hAA, "select");
		for (int i = 0; i < 12; i++) begin
			key = i < 2 ? (i ? 8'h5A : 8'hA5) : $random(seed) & 8'hFF;
			wr(8'h00, key);
			rd(8'h00, key, "key");
			rd(8'h10, {key == 8'h5A, key == 8'hA5, 1'b1}, "status");
		end
		wr(8'h00, 8'h5A);
		pe_req <= 1;
		wr(8'h0C, 1);
		wr(8'h08, 1);
		repeat (4) @(posedge clk_i);
		chk("busy", 0, busy);
		chk("pe_enable", 1, pe);
		wr(8'h00, 8'hA5);
		repeat (3) @(posedge clk_i);
		chk("pe_enable", 0, pe);
		wr(8'h08, 1);
		repeat (3) @(posedge clk_i);
		chk("busy", 1, busy);
		chk("routine", 1, rout);
		repeat (20) @(posedge clk_i);
		rd(8'h0C, 0, "code_select");
		foreach (sels[i]) begin
			wr(8'h04, sels[i]);
			repeat (2) @(posedge clk_i);
			chk("boot_sel", sels[i] == 8'hAA, sel);
			rd(8'h04, sels[i], "select");
		end
		prog <= 1;
		repeat (5) @(posedge clk_i);
		chk("boot_sel", 0, sel);
		rd(8'h04, 32'hAA, "select");
		rd(8'h14, 0, "unmapped");
		chk("slverr", 1, e);
		summarize();
	end
endmodule
